// file: dv/core_model.sv
// Purpose: phy core side supplying paged register bytes
// Assumes: combinational answer to the paged index
// Notes: byte pattern names page, port and index lsb
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic [2:0] page_sel,
	input wire logic [3:0] port_sel,
	input wire logic [2:0] paged_index,
	output logic [7:0] paged_rdata
);
	assign paged_rdata = {page_sel, port_sel, paged_index[0]};
endmodule : core_model
`default_nettype wire

// file: dv/phy_base_registers_bench.sv
// Purpose: self-checking bench for the phy register bank
// Assumes: strobes held high, ce dropped only in the clock enable test, long reset shortened
// Notes: apb master with one idle cycle between transfers
`timescale 1ns/1ps
`default_nettype none
module phy_base_registers_bench;
	localparam int unsigned LONG_N = 40;
	localparam int unsigned SHORT_N = 260;
	logic pclk = 1'h0, presetn = 1'h0, ce = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'hF, port_sel;
	logic pready, pslverr, line_busy = 1'h0, cable_power_in = 1'h1, link_power_status = 1'h1;
	phy_regs_pkg::phy_events_t events = 8'h00;
	logic [5:0] node_number_in = 6'h0, gap_in = 6'h0, gap_count;
	logic [2:0] power_class_pins = 3'h5, page_sel, paged_index;
	logic link_on_req = 1'h0, cl_strap = 1'h1;
	logic contender_linkon_in, contender_linkon_out, contender_linkon_oe;
	logic [7:0] paged_rdata;
	logic node_number_valid, root_holdoff, bus_reset_drive, bus_reset_long;
	phy_regs_pkg::self_id_fields_t self_id_fields;
	int err_total = 0;
	int n_compared = 0;
	assign contender_linkon_in = contender_linkon_oe ? contender_linkon_out : cl_strap;
	always #2.5 pclk = ~pclk;
	phy_base_registers #(.LONG_RESET_CYCLES(LONG_N)) dut_u (.pclk, .presetn, .ce, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .events,
		.node_number_in, .gap_in, .cable_power_in, .link_power_status, .line_busy,
		.power_class_pins, .link_on_req, .contender_linkon_in, .contender_linkon_out,
		.contender_linkon_oe, .paged_rdata, .page_sel, .port_sel, .paged_index,
		.node_number_valid, .gap_count, .root_holdoff, .accel_arbitration_enable(),
		.mixed_speed_concat_enable(), .bus_reset_drive, .bus_reset_long, .self_id_fields);
	core_model core_u (.page_sel, .port_sel, .paged_index, .paged_rdata);
	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			$display("Error t=%0t got %h exp %h", $time, g, x);
			err_total++;
		end
	endtask : chk
	task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d,
		output logic [31:0] r, output logic e);
		int k;
		@(posedge pclk);
		psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'h1) break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'h0; penable <= 1'h0;
		if (k == 20) begin
			err_total++;
			final_report();
		end
	endtask : apb
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'h1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [31:0] a, input logic [7:0] x);
		logic [31:0] r;
		logic e;
		apb(1'h0, a, 8'h00, r, e);
		chk(r, {24'h0, x});
	endtask : rd
	task automatic pulse(input logic [7:0] v);
		@(posedge pclk);
		events <= phy_regs_pkg::phy_events_t'(v);
		@(posedge pclk);
		events <= phy_regs_pkg::phy_events_t'(8'h00);
	endtask : pulse
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] rv [8] = '{8'h01, 8'h3F, 8'hE3, 8'h40, 8'hC5, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) rd(32'(i * 4), rv[i]);
		wr(32'h08, 8'h00);
		rd(32'h08, 8'hE3);
		chk({27'h0, self_id_fields}, {27'h0, 1'h1, 1'h1, 3'h5});
		chk({31'h0, contender_linkon_oe}, 32'h1);
		$display("test reset done");
	endtask : t_reset
	task automatic t_flags();
		cable_power_in <= 1'h0;
		rd(32'h00, 8'h00);
		rd(32'h14, 8'h10);
		pulse(8'h10);
		rd(32'h14, 8'h30);
		wr(32'h14, 8'h30);
		cable_power_in <= 1'h1;
		rd(32'h14, 8'h00);
		node_number_in <= 6'h2A;
		pulse(8'h60);
		rd(32'h00, 8'hAB);
		chk({31'h0, node_number_valid}, 32'h1);
		pulse(8'h80);
		rd(32'h00, 8'hA9);
		chk({31'h0, node_number_valid}, 32'h0);
		$display("test flags done");
	endtask : t_flags
	task automatic t_gap();
		wr(32'h04, 8'h8A);
		rd(32'h04, 8'h8A);
		pulse(8'h80);
		rd(32'h04, 8'h8A);
		gap_in <= 6'h15;
		pulse(8'h01);
		rd(32'h04, 8'h95);
		pulse(8'h80);
		pulse(8'h80);
		rd(32'h04, 8'hBF);
		wr(32'h04, 8'h3F);
		$display("test gap done");
	endtask : t_gap
	task automatic t_page();
		logic [31:0] r;
		logic e;
		for (int p = 0; p < 8; p++) begin
			wr(32'h1C, 8'(p << 5));
			rd(32'h20, (p >= 2 && p <= 6) ? 8'h00 : {3'(p), 5'h00});
			rd(32'h08, 8'hE3);
		end
		wr(32'h1C, 8'h03);
		rd(32'h24, 8'h00);
		wr(32'h1C, 8'h02);
		rd(32'h24, 8'h05);
		apb(1'h0, 32'h40, 8'h00, r, e);
		chk({31'h0, e}, 32'h1);
		wr(32'h1C, 8'h00);
		$display("test page done");
	endtask : t_page
	task automatic t_long();
		int n;
		line_busy <= 1'h1;
		wr(32'h04, 8'h7F);
		repeat (5) @(posedge pclk);
		chk({31'h0, bus_reset_drive}, 32'h0);
		line_busy <= 1'h0;
		n = 0;
		while (bus_reset_drive !== 1'h1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, bus_reset_long}, 32'h1);
		n = 0;
		while (bus_reset_drive === 1'h1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(n), 32'(LONG_N));
		rd(32'h04, 8'h3F);
		wr(32'h14, 8'h40);
		n = 0;
		while (bus_reset_drive !== 1'h1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, bus_reset_long}, 32'h0);
		n = 0;
		while (bus_reset_drive === 1'h1 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(n), 32'(SHORT_N));
		rd(32'h14, 8'h00);
		$display("test long reset done");
	endtask : t_long
	task automatic t_ce();
		ce <= 1'h0;
		pulse(8'h08);
		chk({31'h0, pready}, 32'h0);
		ce <= 1'h1;
		rd(32'h14, 8'h00);
		pulse(8'h08);
		rd(32'h14, 8'h08);
		wr(32'h14, 8'h08);
		rd(32'h14, 8'h00);
		$display("test clock enable done");
	endtask : t_ce
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_flags();
		t_gap();
		t_page();
		t_ce();
		t_long();
		final_report();
	end
endmodule : phy_base_registers_bench
bind phy_base_registers phy_regs_sva #(.LONG_RESET_CYCLES(LONG_RESET_CYCLES)) chk_u (.pclk,
	.presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .line_busy,
	.events, .gap_in, .cable_power_in, .link_power_status, .contender_linkon_oe, .page_sel,
	.node_number_valid, .gap_count, .root_holdoff, .bus_reset_drive, .bus_reset_long,
	.self_id_fields);
`default_nettype wire

// file: dv/phy_regs_sva.sv
// Purpose: port-level checker for the phy register bank
// Assumes: ce held high, one clock domain
// Notes: attached by bind from the bench top
`timescale 1ns/1ps
`default_nettype none
module phy_regs_sva #(
	parameter int unsigned LONG_RESET_CYCLES = 40
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic line_busy,
	input wire phy_regs_pkg::phy_events_t events,
	input wire logic [5:0] gap_in,
	input wire logic cable_power_in,
	input wire logic link_power_status,
	input wire logic contender_linkon_oe,
	input wire logic [2:0] page_sel,
	input wire logic node_number_valid,
	input wire logic [5:0] gap_count,
	input wire logic root_holdoff,
	input wire logic bus_reset_drive,
	input wire logic bus_reset_long,
	input wire phy_regs_pkg::self_id_fields_t self_id_fields
);
	logic wr1;
	logic rd_set;
	logic [5:0] wgap;
	logic [31:0] long_cnt;
	assign wr1 = ce && psel && penable && pwrite && pstrb[0] && paddr == 32'h4;
	assign rd_set = ce && psel && !penable && !pwrite && paddr[31:6] == 26'h0 && paddr[1:0] == 2'h0;
	assign wgap = pwdata[5:0];
	////////////////////////////////////////////////////////////////////////////////
	// cycles spent in long reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) long_cnt <= 32'h0;
		else if (bus_reset_long) long_cnt <= long_cnt + 32'h1;
		else long_cnt <= 32'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_long_end;
		$fell(bus_reset_long);
	endsequence
	sequence s_drive_start;
		$rose(bus_reset_drive);
	endsequence
	AST_OE_STRAP: assert property ($rose(presetn) |-> !contender_linkon_oe)
		else $error("pin driven at strap");
	AST_GAP_HW: assert property ($rose(presetn) |-> gap_count == 6'h3F)
		else $error("gap not 3F after reset");
	AST_GAP_WR: assert property (wr1 |=> gap_count == $past(wgap))
		else $error("gap write lost");
	AST_GAP_PKT: assert property (events.gap_load && !wr1 |=> gap_count == $past(gap_in))
		else $error("gap packet lost");
	AST_NODE_CLR: assert property (events.bus_reset && !events.self_id_done |=> !node_number_valid)
		else $error("node valid after bus reset");
	AST_HOLDOFF: assert property (events.bus_reset && !wr1 |=> $stable(root_holdoff))
		else $error("holdoff changed by bus reset");
	AST_LINK_AND: assert property (self_id_fields.link_bit |-> link_power_status)
		else $error("link bit without link power");
	AST_LONG_LEN: assert property (s_long_end |-> long_cnt == LONG_RESET_CYCLES)
		else $error("long reset length wrong");
	AST_IDLE_START: assert property (s_drive_start |-> !$past(line_busy))
		else $error("reset started while busy");
	AST_RSVD_PAGE: assert property (rd_set && paddr[5] && page_sel >= 3'h2 && page_sel <= 3'h6
		|=> prdata == 32'h0)
		else $error("reserved page not zero");
	AST_CPS: assert property (rd_set && paddr == 32'h0 |=> prdata[0] == $past(cable_power_in))
		else $error("cable power bit wrong");
endmodule : phy_regs_sva
`default_nettype wire

// file: rtl/phy_base_registers.sv
// Purpose: base and paged register bank of a three-port serial-bus phy, apb slave
// Assumes: all inputs synchronous to pclk, phy core supplies event pulses and paged data
// Notes: zero-wait apb while ce is high (pready follows ce), read data sampled in the setup cycle
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "phy_regs_defines.svh"

// Functional notes
// - sixteen registers: indices 0-7 fixed, 8h-Fh paged
// - page select field in register 7 picks one of eight pages
// - base register contents never depend on selected page
// - reserved registers and fields read zero
// - pages two through six read zero entirely
// - node number invalid from bus reset until self-id completes
// - root flag cleared by bus reset, set when node becomes root
// - cable power flag mirrors cable power input, zero means dropped
// - root holdoff writable, cleared by hardware reset, kept by bus reset
// - writing one to long reset request starts 166 us bus reset
// - long reset waits for traffic to end; request cleared by resets
// - six-bit gap set by register write or config packet
// - gap to 3Fh on hardware reset or two resets without update
// - extended set code reads 111b
// - port count reads three
// - speed capability reads 010b
// - repeater latency field reads zero
// - link active set by hardware reset, AND with link power into self-id
// - contender loads pin level at hardware reset, copied to self-id
// - repeater spread field reads zero
// - contender/link-on pin input only during hardware reset
// - four interrupt flags cleared by hardware reset or writing one
// - power class loads from pins at hardware reset, kept by bus reset
// - page zero with unimplemented port reads zero
module phy_base_registers #(
	parameter int unsigned LONG_RESET_CYCLES = `LONG_RESET_CYCLES,
	parameter int unsigned SHORT_RESET_CYCLES = `SHORT_RESET_CYCLES,
	parameter int unsigned CNT_W = 16,
	parameter logic [3:0] PORT_COUNT = `NUM_PORTS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire phy_regs_pkg::phy_events_t events,
	input wire logic [5:0] node_number_in,
	input wire logic [5:0] gap_in,
	input wire logic cable_power_in,
	input wire logic link_power_status,
	input wire logic line_busy,
	input wire logic [2:0] power_class_pins,
	input wire logic link_on_req,
	input wire logic contender_linkon_in,
	output logic contender_linkon_out,
	output logic contender_linkon_oe,
	input wire logic [7:0] paged_rdata,
	output logic [2:0] page_sel,
	output logic [3:0] port_sel,
	output logic [2:0] paged_index,
	output logic node_number_valid,
	output logic [5:0] gap_count,
	output logic root_holdoff,
	output logic accel_arbitration_enable,
	output logic mixed_speed_concat_enable,
	output logic bus_reset_drive,
	output logic bus_reset_long,
	output phy_regs_pkg::self_id_fields_t self_id_fields
);

	////////////////////////////////////////////////////////////////////////
	// declarations
	logic [5:0] node_number;
	logic root_flag;
	logic long_reset_request;
	logic short_reset_request;
	logic link_active;
	logic contender;
	logic [2:0] pwr_class;
	logic resume_event_enable;
	logic config_timeout_flag;
	logic cable_power_drop_flag;
	logic state_timeout_flag;
	logic port_event_flag;
	logic cable_power_prev;
	logic gap_armed;
	logic strap_pending;
	phy_regs_pkg::reset_state_t state;
	phy_regs_pkg::reset_state_t next_state;
	logic [CNT_W-1:0] count;
	logic reset_done;
	logic any_bus_reset;
	logic setup_rd;
	logic wr_go;
	logic addr_ok;
	logic [3:0] idx;
	logic [7:0] wbyte;
	logic [7:0] next_rbyte;

	////////////////////////////////////////////////////////////////////////
	// apb decode
	assign idx = paddr[5:2];
	assign wbyte = pwdata[7:0];
	assign addr_ok = (paddr < `ADDR_SPAN) && (paddr[1:0] == 2'b00);
	assign pready = ce;
	assign pslverr = psel && penable && !addr_ok;
	assign setup_rd = ce && psel && !penable && !pwrite && addr_ok;
	assign wr_go = ce && psel && penable && pwrite && addr_ok && pstrb[0];
	assign any_bus_reset = events.bus_reset || reset_done;

	////////////////////////////////////////////////////////////////////////
	// node identity and root
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			node_number <= 6'h00;
			node_number_valid <= 1'b0;
		end else if (ce) begin
			if (any_bus_reset) begin
				node_number_valid <= 1'b0;
			end else if (events.self_id_done) begin
				node_number <= node_number_in;
				node_number_valid <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			root_flag <= 1'b0;
		end else if (ce) begin
			if (any_bus_reset) begin
				root_flag <= 1'b0;
			end else if (events.root_found) begin
				root_flag <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset_control_gap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			root_holdoff <= 1'b0;
		end else if (ce && wr_go && idx == `IDX_RESET_CONTROL_GAP) begin
			root_holdoff <= wbyte[`ROOT_HOLDOFF_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			long_reset_request <= 1'b0;
		end else if (ce) begin
			if (wr_go && idx == `IDX_RESET_CONTROL_GAP && wbyte[`LONG_RESET_BIT]) begin
				long_reset_request <= 1'b1;
			end else if (any_bus_reset) begin
				long_reset_request <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_count <= `GAP_RESET;
			gap_armed <= 1'b0;
		end else if (ce) begin
			if (wr_go && idx == `IDX_RESET_CONTROL_GAP) begin
				gap_count <= wbyte[`GAP_MSB:`GAP_LSB];
				gap_armed <= 1'b0;
			end else if (events.gap_load) begin
				gap_count <= gap_in;
				gap_armed <= 1'b0;
			end else if (any_bus_reset) begin
				if (gap_armed) begin
					gap_count <= `GAP_RESET;
				end
				gap_armed <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link_contender_power and pin strap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_active <= 1'b1;
		end else if (ce && wr_go && idx == `IDX_LINK_CONTENDER_POWER) begin
			link_active <= wbyte[`LINK_ACTIVE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_pending <= 1'b1;
			contender <= 1'b0;
			pwr_class <= 3'h0;
		end else if (ce) begin
			if (strap_pending) begin
				strap_pending <= 1'b0;
				contender <= contender_linkon_in;
				pwr_class <= power_class_pins;
			end else if (wr_go && idx == `IDX_LINK_CONTENDER_POWER) begin
				contender <= wbyte[`CONTENDER_BIT];
				pwr_class <= wbyte[`PWR_CLASS_MSB:`PWR_CLASS_LSB];
			end
		end
	end

	assign contender_linkon_oe = !strap_pending;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			contender_linkon_out <= 1'b0;
		end else if (ce) begin
			contender_linkon_out <= link_on_req && !strap_pending;
		end
	end

	assign self_id_fields.link_bit = link_active && link_power_status;
	assign self_id_fields.contender_bit = contender;
	assign self_id_fields.pwr_class = pwr_class;

	////////////////////////////////////////////////////////////////////////
	// interrupt_and_feature
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resume_event_enable <= 1'b0;
			accel_arbitration_enable <= 1'b0;
			mixed_speed_concat_enable <= 1'b0;
		end else if (ce && wr_go && idx == `IDX_INTERRUPT_AND_FEATURE) begin
			resume_event_enable <= wbyte[`RESUME_EN_BIT];
			accel_arbitration_enable <= wbyte[`ACCEL_ARB_BIT];
			mixed_speed_concat_enable <= wbyte[`MIXED_SPEED_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			short_reset_request <= 1'b0;
		end else if (ce) begin
			if (wr_go && idx == `IDX_INTERRUPT_AND_FEATURE && wbyte[`SHORT_RESET_BIT]) begin
				short_reset_request <= 1'b1;
			end else if (any_bus_reset) begin
				short_reset_request <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cable_power_prev <= 1'b1;
		end else if (ce) begin
			cable_power_prev <= cable_power_in;
		end
	end

	sticky_flag u_config_timeout (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.set(events.config_timeout),
		.clear(wr_go && idx == `IDX_INTERRUPT_AND_FEATURE && wbyte[`CONFIG_TO_BIT]),
		.flag(config_timeout_flag)
	);

	sticky_flag u_cable_drop (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.set(cable_power_prev && !cable_power_in),
		.clear(wr_go && idx == `IDX_INTERRUPT_AND_FEATURE && wbyte[`CABLE_DROP_BIT]),
		.flag(cable_power_drop_flag)
	);

	sticky_flag u_state_timeout (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.set(events.state_timeout),
		.clear(wr_go && idx == `IDX_INTERRUPT_AND_FEATURE && wbyte[`STATE_TO_BIT]),
		.flag(state_timeout_flag)
	);

	sticky_flag u_port_event (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.set(events.port_change || (resume_event_enable && events.resume_start)),
		.clear(wr_go && idx == `IDX_INTERRUPT_AND_FEATURE && wbyte[`PORT_EVENT_BIT]),
		.flag(port_event_flag)
	);

	////////////////////////////////////////////////////////////////////////
	// page_and_port_select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_sel <= 3'h0;
			port_sel <= 4'h0;
		end else if (ce && wr_go && idx == `IDX_PAGE_AND_PORT_SELECT) begin
			page_sel <= wbyte[`PAGE_MSB:`PAGE_LSB];
			port_sel <= wbyte[`PORT_MSB:`PORT_LSB];
		end
	end

	assign paged_index = idx[2:0];

	////////////////////////////////////////////////////////////////////////
	// bus reset sequencer
	always_comb begin
		next_state = state;
		case (state)
			phy_regs_pkg::RST_IDLE: begin
				if (long_reset_request || short_reset_request) begin
					next_state = phy_regs_pkg::RST_WAIT;
				end
			end
			phy_regs_pkg::RST_WAIT: begin
				if (events.bus_reset) begin
					next_state = phy_regs_pkg::RST_IDLE;
				end else if (!line_busy) begin
					next_state = long_reset_request ? phy_regs_pkg::RST_LONG
						: phy_regs_pkg::RST_SHORT;
				end
			end
			phy_regs_pkg::RST_LONG: begin
				if (count == CNT_W'(LONG_RESET_CYCLES - 1)) begin
					next_state = phy_regs_pkg::RST_IDLE;
				end
			end
			phy_regs_pkg::RST_SHORT: begin
				if (count == CNT_W'(SHORT_RESET_CYCLES - 1)) begin
					next_state = phy_regs_pkg::RST_IDLE;
				end
			end
			default: begin
				next_state = phy_regs_pkg::RST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= phy_regs_pkg::RST_IDLE;
			count <= '0;
		end else if (ce) begin
			state <= next_state;
			if (next_state != state) begin
				count <= '0;
			end else begin
				count <= count + 1'b1;
			end
		end
	end

	assign bus_reset_drive = (state == phy_regs_pkg::RST_LONG) || (state == phy_regs_pkg::RST_SHORT);
	assign bus_reset_long = (state == phy_regs_pkg::RST_LONG);
	assign reset_done = bus_reset_drive && (next_state == phy_regs_pkg::RST_IDLE) && ce;

	////////////////////////////////////////////////////////////////////////
	// read mux, bit position 0 is the lsb
	always_comb begin
		next_rbyte = 8'h00;
		if (idx == `IDX_NODE_IDENTITY_STATUS) begin
			next_rbyte = {node_number, root_flag, cable_power_in};
		end else if (idx == `IDX_RESET_CONTROL_GAP) begin
			next_rbyte = {root_holdoff, long_reset_request, gap_count};
		end else if (idx == `IDX_EXTENSION_PORT_COUNT) begin
			next_rbyte = {`EXTENDED_CODE, 1'b0, PORT_COUNT};
		end else if (idx == `IDX_SPEED_AND_LATENCY) begin
			next_rbyte = {`SPEED_CODE, 1'b0, `DELAY_CODE};
		end else if (idx == `IDX_LINK_CONTENDER_POWER) begin
			next_rbyte = {link_active, contender, `JITTER_CODE, pwr_class};
		end else if (idx == `IDX_INTERRUPT_AND_FEATURE) begin
			next_rbyte = {resume_event_enable, short_reset_request, config_timeout_flag,
				cable_power_drop_flag, state_timeout_flag, port_event_flag,
				accel_arbitration_enable, mixed_speed_concat_enable};
		end else if (idx == `IDX_PAGE_AND_PORT_SELECT) begin
			next_rbyte = {page_sel, 1'b0, port_sel};
		end else if (idx >= `IDX_FIRST_PAGED) begin
			if (page_sel >= `PAGE_RSVD_FIRST && page_sel <= `PAGE_RSVD_LAST) begin
				next_rbyte = 8'h00;
			end else if (page_sel == 3'h0 && port_sel >= PORT_COUNT) begin
				next_rbyte = 8'h00;
			end else begin
				next_rbyte = paged_rdata;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_rd) begin
			prdata <= {24'h00_0000, next_rbyte};
		end
	end

endmodule : phy_base_registers
`default_nettype wire

// file: rtl/phy_regs_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the base register bank
// Assumes: byte address is four times the register index, one register per aligned word
// Notes: bit position 0 of an 8-bit register is its lsb
`ifndef PHY_REGS_DEFINES_SVH
`define PHY_REGS_DEFINES_SVH

// register indices
`define IDX_NODE_IDENTITY_STATUS 4'h0
`define IDX_RESET_CONTROL_GAP 4'h1
`define IDX_EXTENSION_PORT_COUNT 4'h2
`define IDX_SPEED_AND_LATENCY 4'h3
`define IDX_LINK_CONTENDER_POWER 4'h4
`define IDX_INTERRUPT_AND_FEATURE 4'h5
`define IDX_RESERVED_SIX 4'h6
`define IDX_PAGE_AND_PORT_SELECT 4'h7
`define IDX_FIRST_PAGED 4'h8
`define ADDR_SPAN 32'h0000_0040

// node_identity_status fields
`define NODE_NUMBER_MSB 7
`define NODE_NUMBER_LSB 2
`define ROOT_BIT 1
`define CABLE_POWER_BIT 0

// reset_control_gap fields
`define ROOT_HOLDOFF_BIT 7
`define LONG_RESET_BIT 6
`define GAP_MSB 5
`define GAP_LSB 0
`define GAP_RESET 6'h3F

// constant register fields
`define EXTENDED_CODE 3'h7
`define NUM_PORTS 4'h3
`define SPEED_CODE 3'h2
`define DELAY_CODE 4'h0
`define JITTER_CODE 3'h0

// link_contender_power fields
`define LINK_ACTIVE_BIT 7
`define CONTENDER_BIT 6
`define PWR_CLASS_MSB 2
`define PWR_CLASS_LSB 0

// interrupt_and_feature fields
`define RESUME_EN_BIT 7
`define SHORT_RESET_BIT 6
`define CONFIG_TO_BIT 5
`define CABLE_DROP_BIT 4
`define STATE_TO_BIT 3
`define PORT_EVENT_BIT 2
`define ACCEL_ARB_BIT 1
`define MIXED_SPEED_BIT 0

// page_and_port_select fields
`define PAGE_MSB 7
`define PAGE_LSB 5
`define PORT_MSB 3
`define PORT_LSB 0
`define PAGE_RSVD_FIRST 3'h2
`define PAGE_RSVD_LAST 3'h6

// timing
`define CLK_PERIOD_PS 5000
`define LONG_RESET_NS 166000
`define SHORT_RESET_NS 1300
`define LONG_RESET_CYCLES ((`LONG_RESET_NS * 1000) / `CLK_PERIOD_PS)
`define SHORT_RESET_CYCLES ((`SHORT_RESET_NS * 1000) / `CLK_PERIOD_PS)

`endif

// file: rtl/phy_regs_pkg.sv
// Purpose: types shared by the register bank and its bench
// Assumes: constants live in phy_regs_defines.svh
// Notes: one-hot codes for the reset sequencer
package phy_regs_pkg;

	typedef enum logic [3:0] {
		RST_IDLE = 4'b0001,
		RST_WAIT = 4'b0010,
		RST_LONG = 4'b0100,
		RST_SHORT = 4'b1000
	} reset_state_t;

	// events from the phy core, one-cycle pulses
	typedef struct packed {
		logic bus_reset;
		logic self_id_done;
		logic root_found;
		logic config_timeout;
		logic state_timeout;
		logic port_change;
		logic resume_start;
		logic gap_load;
	} phy_events_t;

	// fields carried into the self-id packet
	typedef struct packed {
		logic link_bit;
		logic contender_bit;
		logic [2:0] pwr_class;
	} self_id_fields_t;

endpackage : phy_regs_pkg

// file: rtl/sticky_flag.sv
// Purpose: one hardware-set, write-one-to-clear status flag
// Assumes: set and clear are single-cycle qualified pulses
// Notes: set wins over clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic set,
	input wire logic clear,
	output logic flag
);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag <= 1'b0;
		end else if (ce) begin
			if (set) begin
				flag <= 1'b1;
			end else if (clear) begin
				flag <= 1'b0;
			end
		end
	end

endmodule : sticky_flag
`default_nettype wire
